/* bench/bfps_power_stage.sv */
// Purpose: Power stage and comparator model beside the sequencer
// Assumes: Bench sets the overload level and the probe voltage code
// Notes:   Ramp length is short so soft-start fits a quick run
`timescale 1ns/1ns
module bfps_power_stage #(
   parameter int RAMP_CYC = 400
) (
   // Clock
   input  wire logic       sys_clk,
   // Bench control
   input  wire logic       overload,
   input  wire logic [7:0] probe_code,
   // Gate side
   input  wire logic       high_side_gate,
   input  wire logic       low_side_gate,
   input  wire logic       limit_probe_en,
   input  wire logic       softstart_discharge,
   // Comparator side
   output logic            overcurrent_trip,
   output logic [7:0]      limit_sample,
   output logic            ramp_done
);
   int         ramp_cnt = 0;
   logic [7:0] pin_code = 8'h00;
   assign limit_sample = pin_code;
   // Current is only sensed through the low side switch
   assign overcurrent_trip = overload & low_side_gate & ~high_side_gate;
   assign ramp_done = (ramp_cnt >= RAMP_CYC);
   always @(posedge sys_clk) begin
      // Probe off leaves the pin floating, so the code keeps changing
      pin_code <= limit_probe_en ? probe_code : ~pin_code;
      ramp_cnt <= softstart_discharge ? 0 : ramp_cnt + 1;
   end
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the fault protection sequencer
// Assumes: Hiccup and output ok counts shortened by parameter
// Notes:   Expectations queue up; a monitor compares them in order
`timescale 1ns/1ns
module tb_top;
   import bfps_pkg::*;
   localparam int HIC = 200;
   logic sys_clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0;
   logic pwm_req = 0, cycle_start = 0, supply_lockout = 1;
   logic overvoltage_trip = 0, above_110_pct = 0, above_nominal = 0;
   logic feedback_in_window = 1, temp_above_160 = 0, temp_below_145 = 1;
   logic overload = 0, snap_req = 0, rd_d = 0, snap_d = 0;
   logic [7:0] addr = 8'h00, probe_code = 8'h00, limit_sample, limit_ref;
   logic [31:0] wdata = 32'h0, rdata;
   logic overcurrent_trip, ramp_done, high_side_gate, low_side_gate;
   logic softstart_discharge, ref_clamp_min, limit_probe_en, output_ok_flag;
   logic [5:0] obs;
   int num_errors = 0, n_checks = 0, ticks = 0, pcnt = 0, duty = 5;
   logic [63:0] notes[$];
   assign obs = {ref_clamp_min, limit_probe_en, softstart_discharge,
                 output_ok_flag, low_side_gate, high_side_gate};
   bfps_sequencer #(.HICCUP_CYCLES(HIC_W'(HIC)), .PG_CYCLES(PG_W'(10)))
   bfps_sequencer_i (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .pwm_req(pwm_req), .cycle_start(cycle_start),
      .limit_sample(limit_sample), .supply_lockout(supply_lockout),
      .overcurrent_trip(overcurrent_trip),
      .overvoltage_trip(overvoltage_trip), .above_110_pct(above_110_pct),
      .above_nominal(above_nominal), .feedback_in_window(feedback_in_window),
      .temp_above_160(temp_above_160), .temp_below_145(temp_below_145),
      .ramp_done(ramp_done), .high_side_gate(high_side_gate),
      .low_side_gate(low_side_gate),
      .softstart_discharge(softstart_discharge),
      .ref_clamp_min(ref_clamp_min), .limit_probe_en(limit_probe_en),
      .limit_ref(limit_ref), .output_ok_flag(output_ok_flag));
   bfps_power_stage bfps_power_stage_i (.sys_clk(sys_clk),
      .overload(overload), .probe_code(probe_code),
      .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
      .limit_probe_en(limit_probe_en),
      .softstart_discharge(softstart_discharge),
      .overcurrent_trip(overcurrent_trip), .limit_sample(limit_sample),
      .ramp_done(ramp_done));
   always #50 sys_clk = ~sys_clk;
   task automatic end_of_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [63:0] note);
      n_checks++;
      if (((seen ^ note[31:0]) & note[63:32]) !== 32'h0) begin
         num_errors++;
         $display("[ERR] %0t saw %h want %h mask %h", $time, seen,
                  note[31:0], note[63:32]);
      end
   endtask
   // Modulator stand-in: 16-cycle switching period, random duty
   always @(posedge sys_clk) begin
      ticks <= ticks + 1;
      pcnt <= (pcnt == 15) ? 0 : pcnt + 1;
      cycle_start <= (pcnt == 15);
      pwm_req <= (((pcnt + 1) % 16) < duty);
      if (pcnt == 15) begin
         duty <= $urandom_range(8, 3);
      end
      if (ticks == 12000) begin
         num_errors++;
         end_of_test();
      end
   end
   // Results stand one cycle after their request
   always @(posedge sys_clk) begin
      rd_d <= rd_stb;
      snap_d <= snap_req;
      if (rd_d || snap_d) begin
         if (notes.size() == 0) begin
            num_errors++;
            $display("[ERR] %0t result with nothing expected", $time);
         end else begin
            chk(rd_d ? rdata : {26'h0, obs}, notes.pop_front());
         end
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      notes.push_back({m, e});
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
   endtask
   task automatic snap(input logic [5:0] m, e);
      notes.push_back({26'h0, m, 26'h0, e});
      @(posedge sys_clk);
      snap_req <= 1'b1;
      @(posedge sys_clk);
      snap_req <= 1'b0;
   endtask
   task automatic st(input logic [2:0] s);
      rd(ADDR_STATUS, 32'h7, {29'h0, s});
   endtask
   // One overload burst in a low-side period, then sit in the next one
   task automatic pulse();
      @(posedge sys_clk iff cycle_start);
      cyc(9);
      overload <= 1'b1;
      cyc(3);
      overload <= 1'b0;
      @(posedge sys_clk iff cycle_start);
      cyc(5);
   endtask
   initial begin
      void'($urandom(32'h2696f108));
      probe_code <= 8'($urandom_range(254, 1));
      cyc(12);
      reset_n <= 1'b1;
      snap(6'h37, 6'h00);
      wr(ADDR_CTRL, 32'h3);
      cyc(5);
      rd(ADDR_CTRL, 32'h3, 32'h3);
      rd(ADDR_STATUS, 32'h247, 32'h200);
      supply_lockout <= 1'b0;
      cyc(6);
      st(3'h1);
      snap(6'h13, 6'h10);
      cyc(1000);
      rd(ADDR_LIMIT, 32'hff, {24'h0, probe_code});
      wr(ADDR_LIMIT, 32'h0);
      rd(8'h0c, 32'hffffffff, 32'h0);
      rd(ADDR_LIMIT, 32'hff, {24'h0, probe_code});
      cyc(450);
      st(3'h3);
      snap(6'h04, 6'h04);
      repeat (3) begin
         pulse();
         rd(ADDR_STATUS, 32'h87, 32'h83);
         snap(6'h03, 6'h02);
      end
      cyc(40);
      rd(ADDR_STATUS, 32'h87, 32'h03);
      @(posedge sys_clk iff cycle_start);
      overload <= 1'b1;
      cyc(60);
      st(3'h4);
      snap(6'h0b, 6'h08);
      overload <= 1'b0;
      cyc(HIC);
      rd(ADDR_STATUS, 32'h107, 32'h102);
      snap(6'h20, 6'h20);
      overvoltage_trip <= 1'b1;
      above_110_pct <= 1'b1;
      above_nominal <= 1'b1;
      cyc(5);
      rd(ADDR_STATUS, 32'h37, 32'h12);
      snap(6'h03, 6'h02);
      overvoltage_trip <= 1'b0;
      cyc(5);
      rd(ADDR_STATUS, 32'h30, 32'h10);
      snap(6'h03, 6'h02);
      above_110_pct <= 1'b0;
      cyc(5);
      rd(ADDR_STATUS, 32'h30, 32'h20);
      snap(6'h03, 6'h00);
      above_nominal <= 1'b0;
      cyc(5);
      rd(ADDR_STATUS, 32'h30, 32'h00);
      overload <= 1'b1;
      cyc(60);
      st(3'h4);
      overload <= 1'b0;
      cyc(HIC + 450);
      st(3'h3);
      feedback_in_window <= 1'b0;
      cyc(4);
      snap(6'h04, 6'h00);
      feedback_in_window <= 1'b1;
      cyc(4);
      snap(6'h04, 6'h00);
      cyc(20);
      snap(6'h04, 6'h04);
      temp_below_145 <= 1'b0;
      temp_above_160 <= 1'b1;
      cyc(5);
      st(3'h5);
      snap(6'h0b, 6'h08);
      temp_above_160 <= 1'b0;
      cyc(10);
      st(3'h5);
      temp_below_145 <= 1'b1;
      cyc(5);
      st(3'h2);
      wr(ADDR_CTRL, 32'h0);
      temp_below_145 <= 1'b0;
      temp_above_160 <= 1'b1;
      cyc(5);
      st(3'h0);
      temp_above_160 <= 1'b0;
      temp_below_145 <= 1'b1;
      wr(ADDR_CTRL, 32'h1);
      cyc(5);
      st(3'h1);
      supply_lockout <= 1'b1;
      cyc(5);
      rd(ADDR_STATUS, 32'h247, 32'h200);
      snap(6'h17, 6'h00);
      cyc(3);
      end_of_test();
   end
endmodule

/* logic/bfps_pkg.sv */
// Purpose: Constants shared by the buck fault protection sequencer
// Assumes: 10 MHz block clock
// Notes:   Times kept in their own units, cycle counts derived here
package bfps_pkg;
   localparam int CLK_MHZ      = 10;
   localparam int HICCUP_MS    = 50;
   localparam int PG_DELAY_US  = 1100;
   localparam int INIT_US      = 100;
   localparam int HICCUP_CYC   = HICCUP_MS * 1000 * CLK_MHZ;
   localparam int PG_CYC       = PG_DELAY_US * CLK_MHZ;
   localparam int INIT_CYC     = INIT_US * CLK_MHZ;
   localparam int HIC_W        = 20;
   localparam int PG_W         = 14;
   localparam int INIT_W       = 11;
   localparam int REF_W        = 8;
   localparam int SYNC_W       = 9;
   // Register map, byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LIMIT  = 8'h08;
   // Control fields
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_TRACK   = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_INIT   = 3'b001,
      ST_SOFT   = 3'b010,
      ST_RUN    = 3'b011,
      ST_HICCUP = 3'b100,
      ST_THERM  = 3'b101
   } bfps_state_type;
   typedef enum logic [1:0] {
      OV_NONE = 2'b00,
      OV_PULL = 2'b01,
      OV_PARK = 2'b10
   } bfps_ov_type;
endpackage

/* logic/bfps_sequencer.sv */
// Purpose: Fault handling sequencer of a synchronous buck controller
// Assumes: Comparator results arrive asynchronously; pwm_req and
//          cycle_start come from the on-chip modulator on sys_clk
// Notes:   Long counts are parameters so simulation can shorten them
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module bfps_sequencer
   import bfps_pkg::*;
#(
   parameter logic [HIC_W-1:0] HICCUP_CYCLES = HIC_W'(bfps_pkg::HICCUP_CYC),
   parameter logic [PG_W-1:0]  PG_CYCLES     = PG_W'(bfps_pkg::PG_CYC)
) (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   // Register port
   input  wire logic [7:0]                addr,
   input  wire logic [31:0]               wdata,
   input  wire logic                      wr_stb,
   input  wire logic                      rd_stb,
   output logic [31:0]                    rdata,
   // Modulator, same clock
   input  wire logic                      pwm_req,
   input  wire logic                      cycle_start,
   input  wire logic [bfps_pkg::REF_W-1:0] limit_sample,
   // Analog comparators, asynchronous
   input  wire logic                      supply_lockout,
   input  wire logic                      overcurrent_trip,
   input  wire logic                      overvoltage_trip,
   input  wire logic                      above_110_pct,
   input  wire logic                      above_nominal,
   input  wire logic                      feedback_in_window,
   input  wire logic                      temp_above_160,
   input  wire logic                      temp_below_145,
   input  wire logic                      ramp_done,
   // Power stage and status
   output logic                           high_side_gate,
   output logic                           low_side_gate,
   output logic                           softstart_discharge,
   output logic                           ref_clamp_min,
   output logic                           limit_probe_en,
   output logic [bfps_pkg::REF_W-1:0]     limit_ref,
   output logic                           output_ok_flag
);
   import bfps_pkg::*;

   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic              lockout_s;
   logic              oc_s;
   logic              ov_s;
   logic              ov110_s;
   logic              nom_s;
   logic              win_s;
   logic              hot_s;
   logic              cool_s;
   logic              ramp_s;
   logic [1:0]        ctrl;
   bfps_state_type    state;
   bfps_ov_type       ov_mode;
   logic [HIC_W-1:0]  hic_cnt;
   logic [INIT_W-1:0] init_cnt;
   logic [PG_W-1:0]   pg_cnt;
   logic              oc_seen;
   logic              oc_prev;
   logic              skip;
   logic              from_hiccup;
   logic              switching;
   logic              oc_double;
   logic              next_hs;
   logic              next_ls;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {supply_lockout, overcurrent_trip, overvoltage_trip,
                    above_110_pct, above_nominal, feedback_in_window,
                    temp_above_160, temp_below_145, ramp_done};
         sync_b <= sync_a;
      end
   end
   assign {lockout_s, oc_s, ov_s, ov110_s, nom_s, win_s, hot_s, cool_s,
           ramp_s} = sync_b;

   assign switching = (state == ST_SOFT) || (state == ST_RUN);
   assign oc_double = cycle_start && oc_seen && oc_prev;

   // Control register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= CTRL_RESET;
      end else if (wr_stb && addr == ADDR_CTRL) begin
         ctrl <= wdata[1:0];
      end
   end

   // Read data stand for one cycle after the strobe only
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= '0;
      end else if (!rd_stb) begin
         rdata <= '0;
      end else if (addr == ADDR_CTRL) begin
         rdata <= {30'h0, ctrl};
      end else if (addr == ADDR_STATUS) begin
         rdata <= {22'h0, lockout_s, from_hiccup, skip, output_ok_flag,
                   ov_mode, 1'b0, state};
      end else if (addr == ADDR_LIMIT) begin
         rdata <= {24'h0, limit_ref};
      end else begin
         rdata <= '0;
      end
   end

   // Main sequence
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= ST_OFF;
         hic_cnt     <= '0;
         init_cnt    <= '0;
         from_hiccup <= 1'b0;
         limit_ref   <= '0;
      end else if (lockout_s || !ctrl[CTRL_ENABLE]) begin
         state       <= ST_OFF;
         from_hiccup <= 1'b0;
      end else begin
         case (state)
            ST_OFF: begin
               init_cnt <= '0;
               state    <= ST_INIT;
            end
            ST_INIT: begin
               if (init_cnt == INIT_W'(INIT_CYC - 1)) begin
                  limit_ref <= limit_sample;
                  state     <= ST_SOFT;
               end else begin
                  init_cnt <= init_cnt + 1'b1;
               end
            end
            ST_SOFT, ST_RUN: begin
               if (hot_s) begin
                  state <= ST_THERM;
               end else if (oc_double) begin
                  hic_cnt <= '0;
                  state   <= ST_HICCUP;
               end else if (state == ST_SOFT && ramp_s) begin
                  from_hiccup <= 1'b0;
                  state       <= ST_RUN;
               end
            end
            ST_HICCUP: begin
               // Full off time before the ramp is released again
               if (hic_cnt == HICCUP_CYCLES - 1'b1) begin
                  from_hiccup <= 1'b1;
                  state       <= ST_SOFT;
               end else begin
                  hic_cnt <= hic_cnt + 1'b1;
               end
            end
            ST_THERM: begin
               if (cool_s) begin
                  state <= ST_SOFT;
               end
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   // Overcurrent sampled in the low side period, judged at cycle start
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         oc_seen <= 1'b0;
         oc_prev <= 1'b0;
         skip    <= 1'b0;
      end else if (!switching) begin
         oc_seen <= 1'b0;
         oc_prev <= 1'b0;
         skip    <= 1'b0;
      end else if (cycle_start) begin
         // A trip in the boundary cycle counts for the new cycle
         oc_seen <= oc_s && !pwm_req;
         oc_prev <= oc_seen;
         skip    <= oc_seen;
      end else if (oc_s && !pwm_req) begin
         oc_seen <= 1'b1;
      end
   end

   // Overvoltage hysteresis, armed during soft-start as well
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ov_mode <= OV_NONE;
      end else if (!switching) begin
         ov_mode <= OV_NONE;
      end else if (ov_s) begin
         ov_mode <= OV_PULL;
      end else if (ov_mode == OV_PULL && !ov110_s) begin
         ov_mode <= OV_PARK;
      end else if (ov_mode == OV_PARK && !nom_s) begin
         ov_mode <= OV_NONE;
      end
   end

   always_comb begin
      next_hs = 1'b0;
      next_ls = 1'b0;
      if (switching && !oc_double) begin
         if (ov_mode == OV_PULL || ov_s) begin
            next_ls = 1'b1;
         end else if (ov_mode == OV_PARK) begin
            next_ls = 1'b0;
         end else if (skip) begin
            next_ls = 1'b1;
         end else begin
            next_hs = pwm_req;
            next_ls = !pwm_req;
         end
      end
   end

   // Gates and analog controls; lockout forces both gates and the probe current off
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         high_side_gate      <= 1'b0;
         low_side_gate       <= 1'b0;
         softstart_discharge <= 1'b1;
         ref_clamp_min       <= 1'b0;
         limit_probe_en      <= 1'b0;
      end else begin
         high_side_gate      <= next_hs && !lockout_s;
         low_side_gate       <= next_ls && !lockout_s;
         softstart_discharge <= !switching || oc_double;
         ref_clamp_min       <= state == ST_SOFT && from_hiccup
                                && ctrl[CTRL_TRACK];
         limit_probe_en      <= state == ST_INIT && !lockout_s;
      end
   end

   // Output ok: delayed rise, immediate fall
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pg_cnt         <= '0;
         output_ok_flag <= 1'b0;
      end else if (lockout_s || !switching || !win_s) begin
         pg_cnt         <= '0;
         output_ok_flag <= 1'b0;
      end else if (pg_cnt == PG_CYCLES - 1'b1) begin
         output_ok_flag <= 1'b1;
      end else begin
         pg_cnt <= pg_cnt + 1'b1;
      end
   end

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   lockout_off_a: assert property (
      lockout_s |=> state == ST_OFF)
      else $error("Lockout did not force off state");
   lockout_flag_a: assert property (
      lockout_s |=> !output_ok_flag && !high_side_gate && !low_side_gate)
      else $error("Outputs active under lockout");
   limit_capture_a: assert property (
      state == ST_INIT && $past(state) == ST_INIT ##1 state == ST_SOFT
      |-> limit_ref == $past(limit_sample))
      else $error("Limit not captured on leaving init");
   skip_pulse_a: assert property (
      skip && switching && ov_mode == OV_NONE && !ov_s && !oc_double
      && !lockout_s |=> !high_side_gate && low_side_gate)
      else $error("Skipped pulse drove high side");
   double_oc_a: assert property (
      oc_double && switching && !hot_s && !lockout_s && ctrl[CTRL_ENABLE]
      |=> state == ST_HICCUP && !high_side_gate && !low_side_gate
          && softstart_discharge)
      else $error("Double overcurrent did not enter hiccup");
   hiccup_gates_a: assert property (
      state == ST_HICCUP |=> !high_side_gate && !low_side_gate)
      else $error("Gates on in hiccup");
   single_oc_a: assert property (
      cycle_start && oc_seen && !oc_prev && state == ST_RUN && !hot_s
      && !lockout_s && ctrl[CTRL_ENABLE] |=> state == ST_RUN)
      else $error("Single overcurrent caused hiccup");
   ov_pull_a: assert property (
      switching && ov_s && !oc_double && !lockout_s
      |=> low_side_gate && !high_side_gate)
      else $error("Overvoltage did not pull output down");
   ov_park_a: assert property (
      ov_mode == OV_PARK && !ov_s |=> !high_side_gate && !low_side_gate)
      else $error("Gates on while parked");
   therm_off_a: assert property (
      !ctrl[CTRL_ENABLE] |=> state != ST_THERM)
      else $error("Thermal state while disabled");
   pg_fall_a: assert property (
      !win_s |=> !output_ok_flag)
      else $error("Output ok not dropped at once");
   pg_rise_a: assert property (
      $rose(output_ok_flag) |-> $past(win_s) && $past(pg_cnt)
                                == PG_CYCLES - 1'b1)
      else $error("Output ok rose early");
   probe_init_a: assert property (
      state == ST_INIT && !lockout_s |=> limit_probe_en)
      else $error("Probe current off during init");
   // A discharge that never fires would let the ramp restart from its old level
   discharge_on_a: assert property (
      oc_double |=> softstart_discharge)
      else $error("Hiccup trigger did not discharge soft-start");
   clamp_restart_a: assert property (
      state == ST_SOFT && from_hiccup && ctrl[CTRL_TRACK] |=> ref_clamp_min)
      else $error("Reference not clamped on tracking restart");
   therm_gates_a: assert property (
      state == ST_THERM
      |=> !high_side_gate && !low_side_gate && softstart_discharge)
      else $error("Gates on during thermal shutdown");
   ov_soft_a: assert property (
      state == ST_SOFT && ov_s && !oc_double && !lockout_s
      |=> low_side_gate && !high_side_gate)
      else $error("Overvoltage ignored during soft-start");

   hiccup_c: cover property (state == ST_HICCUP ##1 state == ST_SOFT);
   therm_c:  cover property (state == ST_THERM ##1 state == ST_SOFT);
   pg_c:     cover property ($rose(output_ok_flag));
   park_c:   cover property (ov_mode == OV_PARK ##1 ov_mode == OV_NONE);
   skip_c:   cover property (skip ##1 !skip);
endmodule
